// File: pkg/mpc_params.svh
`ifndef MPC_PARAMS_SVH
`define MPC_PARAMS_SVH
`define MPC_OPC_MUL    6'h10
`define MPC_OPC_MULI   6'h18
`define MPC_OPC_OR     6'h20
`define MPC_OPC_ORI    6'h28
`define MPC_OPC_PCMPEQ 6'h22
`define MPC_OPC_PCMPNE 6'h23
`define MPC_FN_MUL     2'h0
`define MPC_FN_MULH    2'h1
`define MPC_FN_MULHSU  2'h2
`define MPC_FN_MULHU   2'h3
`define MPC_PCMP_BIT   10
`define MPC_SLOW_CYC   2'h3
`define MPC_ONE_CYC    2'h1
`endif

// File: pkg/mpc_pkg.sv
package mpc_pkg;
  typedef enum logic [3:0] {
    MPC_OP_NONE, MPC_OP_MUL, MPC_OP_MULH, MPC_OP_MULHU, MPC_OP_MULHSU,
    MPC_OP_MULI, MPC_OP_OR, MPC_OP_ORI, MPC_OP_BF, MPC_OP_EQ, MPC_OP_NE
  } mpc_op_e;
  typedef enum logic [0:0] {MPC_IDLE, MPC_BUSY} mpc_state_e;
endpackage

// File: core/mpc_unit.sv
// How it works
// - mul keeps low word of product
// - products take 1 or 3 cycles
// - mul, muli need hardware product level
// - mulh: signed high word
// - mulhu: unsigned high word
// - mulhsu: signed by unsigned high word
// - high words need product level 2
// - bits 30, 31 select product variant
// - muli: low word times sign-extended immediate
// - immediate prefix supplies upper half
// - or writes bitwise or, one cycle
// - ori ors sign-extended immediate
// - nop writes no register and raises no illegal
// - byte find returns first match position
// - examine bits 0 to 7 first
// - equal compare gives 1 on match
// - not-equal compare gives 0 on match
// - compares need pattern compare enable
`include "mpc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module mpc_unit #(
  parameter int AREA_OPT_SETTING       = 0,
  parameter int HW_PRODUCT_LEVEL       = 1,
  parameter int PATTERN_COMPARE_ENABLE = 0
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        issue,
  input  wire logic [31:0] instr,
  input  wire logic [31:0] first_source,
  input  wire logic [31:0] second_source,
  input  wire logic        imm_prefix_valid,
  input  wire logic [15:0] imm_prefix_high,
  output logic             busy_ff,
  output logic             wr_en_ff,
  output logic [4:0]       wr_addr_ff,
  output logic [31:0]      wr_data_ff,
  output logic             illegal_ff
);
  // slow mode means area setting 1
  localparam bit SLOW = (AREA_OPT_SETTING == 1);
  localparam bit HAS_MUL = (HW_PRODUCT_LEVEL > 0);
  localparam bit HAS_WIDE = (HW_PRODUCT_LEVEL == 2);
  localparam bit HAS_PCMP = (PATTERN_COMPARE_ENABLE == 1);

  // every check below lives on mclk and sleeps through reset
  default clocking dflt @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  wire logic [5:0]  opc = instr[31:26];
  wire logic [4:0]  dst = instr[25:21];
  // bit 0 big-endian is msb here
  wire logic [1:0]  fn  = instr[1:0];
  wire logic        pc  = instr[`MPC_PCMP_BIT];
  wire logic [31:0] imm_val;
  wire logic [63:0] p_ss;
  wire logic [63:0] p_uu;
  wire logic [63:0] p_su;
  wire logic [31:0] bf_val;
  wire logic        eq;
  mpc_pkg::mpc_op_e dec_op;

  assign imm_val = imm_prefix_valid ? {imm_prefix_high, instr[15:0]}
                 : {{16{instr[15]}}, instr[15:0]};
  assign p_uu = {32'h0, first_source} * {32'h0, second_source};
  // widen before multiplying so the product is formed at 64 bits
  assign p_ss = 64'($signed({{32{first_source[31]}}, first_source})
              * $signed({{32{second_source[31]}}, second_source}));
  assign p_su = 64'($signed({{32{first_source[31]}}, first_source})
              * $signed({32'h0, second_source}));
  assign eq = (first_source == second_source);

  // first equal byte wins; msb is position 1
  function automatic logic [31:0] byte_find(input logic [31:0] a,
                                            input logic [31:0] b);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (r == 32'h0 && a[i*8 +: 8] == b[i*8 +: 8])
      begin
        r = 32'(4 - i);
      end
    end
    return r;
  endfunction
  assign bf_val = byte_find(first_source, second_source);

  // named decode terms keep the priority chain short
  wire logic mul_fmt = (opc == `MPC_OPC_MUL) && (instr[10:2] == 9'h0);
  wire logic muli_op = (opc == `MPC_OPC_MULI);
  wire logic or_op   = (opc == `MPC_OPC_OR);
  wire logic eq_op   = (opc == `MPC_OPC_PCMPEQ);
  wire logic ne_op   = (opc == `MPC_OPC_PCMPNE);
  wire logic ori_op  = (opc == `MPC_OPC_ORI);

  always_comb
  begin
    dec_op = mpc_pkg::MPC_OP_NONE;
    if (mul_fmt && HAS_MUL)
    begin
      unique case (fn)
        `MPC_FN_MUL:    dec_op = mpc_pkg::MPC_OP_MUL;
        `MPC_FN_MULH:   dec_op = HAS_WIDE ? mpc_pkg::MPC_OP_MULH
                                          : mpc_pkg::MPC_OP_NONE;
        `MPC_FN_MULHSU: dec_op = HAS_WIDE ? mpc_pkg::MPC_OP_MULHSU
                                          : mpc_pkg::MPC_OP_NONE;
        `MPC_FN_MULHU:  dec_op = HAS_WIDE ? mpc_pkg::MPC_OP_MULHU
                                          : mpc_pkg::MPC_OP_NONE;
      endcase
    end
    else if (muli_op && HAS_MUL)
      dec_op = mpc_pkg::MPC_OP_MULI;
    else if (or_op && !pc)
      dec_op = mpc_pkg::MPC_OP_OR;
    else if (or_op && pc && HAS_PCMP)
      dec_op = mpc_pkg::MPC_OP_BF;
    else if (eq_op && pc && HAS_PCMP)
      dec_op = mpc_pkg::MPC_OP_EQ;
    else if (ne_op && pc && HAS_PCMP)
      dec_op = mpc_pkg::MPC_OP_NE;
    else if (ori_op)
      dec_op = mpc_pkg::MPC_OP_ORI;
  end

  logic [31:0] res;
  logic        is_prod;
  always_comb
  begin
    res = 32'h0;
    is_prod = 1'b0;
    unique case (dec_op)
      mpc_pkg::MPC_OP_NONE:   res = 32'h0;
      mpc_pkg::MPC_OP_MUL:
      begin
        res = p_uu[31:0];
        is_prod = 1'b1;
      end
      mpc_pkg::MPC_OP_MULH:
      begin
        res = p_ss[63:32];
        is_prod = 1'b1;
      end
      mpc_pkg::MPC_OP_MULHU:
      begin
        res = p_uu[63:32];
        is_prod = 1'b1;
      end
      mpc_pkg::MPC_OP_MULHSU:
      begin
        res = p_su[63:32];
        is_prod = 1'b1;
      end
      mpc_pkg::MPC_OP_MULI:
      begin
        res = 32'(first_source * imm_val);
        is_prod = 1'b1;
      end
      mpc_pkg::MPC_OP_OR:     res = first_source | second_source;
      mpc_pkg::MPC_OP_ORI:    res = first_source | imm_val;
      mpc_pkg::MPC_OP_BF:     res = bf_val;
      mpc_pkg::MPC_OP_EQ:     res = {31'h0, eq};
      mpc_pkg::MPC_OP_NE:     res = {31'h0, !eq};
    endcase
  end

  // slow path holds result until count expires; operands must stay
  // stable only for the issue cycle since result is captured at once
  mpc_pkg::mpc_state_e state_ff, nxt_state;
  logic [1:0]  cnt_ff, nxt_cnt;
  logic [31:0] hold_ff;
  logic [4:0]  hdst_ff;
  wire logic   take = issue && !busy_ff;
  wire logic   go_slow = take && is_prod && SLOW;
  wire logic   ok = dec_op != mpc_pkg::MPC_OP_NONE;
  // r0 and nop writes suppressed
  wire logic   fast_wr = take && ok && !go_slow && dst != 5'h0;
  wire logic   slow_done = state_ff == mpc_pkg::MPC_BUSY
                           && cnt_ff == `MPC_ONE_CYC;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      mpc_pkg::MPC_IDLE:
        if (go_slow)
        begin
          nxt_state = mpc_pkg::MPC_BUSY;
          // the issue cycle is the first of the three
          nxt_cnt = `MPC_SLOW_CYC - `MPC_ONE_CYC;
        end
      mpc_pkg::MPC_BUSY:
        if (slow_done)
          nxt_state = mpc_pkg::MPC_IDLE;
        else
          nxt_cnt = cnt_ff - 2'h1;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= mpc_pkg::MPC_IDLE;
      cnt_ff <= 2'h0;
      hold_ff <= 32'h0;
      hdst_ff <= 5'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      if (go_slow)
      begin
        hold_ff <= res;
        hdst_ff <= dst;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_ff <= 1'b0;
      wr_en_ff <= 1'b0;
      wr_addr_ff <= 5'h0;
      wr_data_ff <= 32'h0;
      illegal_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= (nxt_state == mpc_pkg::MPC_BUSY) && !slow_done;
      wr_en_ff <= fast_wr || (slow_done && hdst_ff != 5'h0);
      wr_addr_ff <= slow_done ? hdst_ff : dst;
      wr_data_ff <= slow_done ? hold_ff : res;
      illegal_ff <= take && !ok;
    end
  end

  // upper word of a 64-bit product, for the checks below
  function automatic logic [31:0] hi_word(input logic [63:0] x,
                                          input logic [63:0] y);
    logic [63:0] p;
    p = x * y;
    return p[63:32];
  endfunction
  // check operands widened apart from the datapath's own products
  wire logic [63:0] chk_a_s = {{32{first_source[31]}}, first_source};
  wire logic [63:0] chk_a_u = {32'h0, first_source};
  wire logic [63:0] chk_b_s = {{32{second_source[31]}}, second_source};
  wire logic [63:0] chk_b_u = {32'h0, second_source};

  a_fast_lat: assert property (
    fast_wr |=> wr_en_ff && wr_data_ff == $past(res))
    else $error("fast result not written next cycle");

  a_slow_lat: assert property (
    go_slow && dst != 5'h0 |=> !wr_en_ff ##1 !wr_en_ff ##1 wr_en_ff)
    else $error("slow product latency wrong");

  a_slow_data: assert property (
    go_slow |-> ##3 wr_data_ff == $past(res, 3))
    else $error("slow product data lost");

  a_busy_hold: assert property (
    go_slow |=> busy_ff [*2] ##1 !busy_ff)
    else $error("busy not held for slow product");

  a_busy_refuse: assert property (
    busy_ff && !slow_done |=> !wr_en_ff && !illegal_ff)
    else $error("issue acted on while busy");

  a_r0_write: assert property (
    wr_en_ff |-> wr_addr_ff != 5'h0)
    else $error("write to register zero");

  a_r0_slow: assert property (
    go_slow && dst == 5'h0 |-> ##3 !wr_en_ff)
    else $error("slow product wrote register zero");

  a_eq_result: assert property (
    fast_wr && dec_op == mpc_pkg::MPC_OP_EQ
      |=> wr_data_ff == {31'h0, $past(eq)})
    else $error("equal compare wrong");

  a_ne_result: assert property (
    fast_wr && dec_op == mpc_pkg::MPC_OP_NE |=> wr_data_ff[0] != $past(eq))
    else $error("not-equal compare wrong");

  a_bf_range: assert property (
    dec_op == mpc_pkg::MPC_OP_BF |-> bf_val <= 32'h4
      && (bf_val == 32'h0) == (first_source[31:24] != second_source[31:24]
      && first_source[23:16] != second_source[23:16]
      && first_source[15:8] != second_source[15:8]
      && first_source[7:0] != second_source[7:0]))
    else $error("byte find out of range");

  a_bf_first: assert property (
    first_source[31:24] == second_source[31:24] |-> bf_val == 32'h1)
    else $error("msb byte not first");

  a_wide_gate: assert property (
    !HAS_WIDE |-> dec_op != mpc_pkg::MPC_OP_MULH
      && dec_op != mpc_pkg::MPC_OP_MULHU
      && dec_op != mpc_pkg::MPC_OP_MULHSU)
    else $error("high product decoded without wide option");

  a_mul_gate: assert property (
    !HAS_MUL |-> dec_op != mpc_pkg::MPC_OP_MUL
      && dec_op != mpc_pkg::MPC_OP_MULI)
    else $error("product decoded without multiplier");

  a_pcmp_gate: assert property (
    !HAS_PCMP |-> dec_op != mpc_pkg::MPC_OP_BF
      && dec_op != mpc_pkg::MPC_OP_EQ && dec_op != mpc_pkg::MPC_OP_NE)
    else $error("compare decoded while disabled");

  a_ill_nowr: assert property (
    illegal_ff |-> !wr_en_ff)
    else $error("illegal word wrote a register");

  a_low_form: assert property (
    dec_op == mpc_pkg::MPC_OP_MUL |-> instr[1:0] == 2'h0)
    else $error("low product decoded with variant bits set");

  a_mul_low: assert property (
    dec_op == mpc_pkg::MPC_OP_MUL
      |-> res == 32'(first_source * second_source))
    else $error("low product word wrong");
  a_mulh_word: assert property (
    dec_op == mpc_pkg::MPC_OP_MULH |-> res == hi_word(chk_a_s, chk_b_s))
    else $error("signed high word wrong");
  a_mulhu_word: assert property (
    dec_op == mpc_pkg::MPC_OP_MULHU |-> res == hi_word(chk_a_u, chk_b_u))
    else $error("unsigned high word wrong");
  a_mulhsu_word: assert property (
    dec_op == mpc_pkg::MPC_OP_MULHSU |-> res == hi_word(chk_a_s, chk_b_u))
    else $error("mixed high word wrong");

  a_muli_low: assert property (
    dec_op == mpc_pkg::MPC_OP_MULI && !imm_prefix_valid
      |-> res == 32'(first_source * {{16{instr[15]}}, instr[15:0]}))
    else $error("immediate product wrong");

  a_imm_prefix: assert property (
    dec_op == mpc_pkg::MPC_OP_ORI && imm_prefix_valid
      |-> res[31:16] == (first_source[31:16] | imm_prefix_high))
    else $error("prefix upper half not used");

  a_or_result: assert property (
    dec_op == mpc_pkg::MPC_OP_OR |-> res == (first_source | second_source))
    else $error("register or wrong");

  a_ori_result: assert property (
    dec_op == mpc_pkg::MPC_OP_ORI && !imm_prefix_valid
      |-> res == (first_source | {{16{instr[15]}}, instr[15:0]}))
    else $error("immediate or wrong");

  a_nop_quiet: assert property (
    take && instr == {`MPC_OPC_OR, 26'h0} |=> !wr_en_ff && !illegal_ff)
    else $error("nop changed state");

  c_slow: cover property (go_slow ##3 wr_en_ff);
  c_fast: cover property (take && is_prod && !SLOW);
  c_bf: cover property (take && dec_op == mpc_pkg::MPC_OP_BF);
  c_ill: cover property (illegal_ff);
  c_refused: cover property (issue && busy_ff);
endmodule // mpc_unit
`default_nettype wire

// File: sim/mpc_wb_model.sv
`timescale 1ns/1ps
`default_nettype none
module mpc_wb_model (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  output var  int          n_wr_ff,
  output var  logic [31:0] last_ff
);
  // only whole results land here: readers never see a half product
  logic [31:0] regs_ff [32];
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      n_wr_ff <= 0;
      last_ff <= 32'h0;
    end
    else if (wr_en)
    begin
      n_wr_ff <= n_wr_ff + 1;
      last_ff <= wr_data;
      if (wr_addr != 5'h00) regs_ff[wr_addr] <= wr_data;
    end
  end
endmodule // mpc_wb_model
`default_nettype wire

// File: sim/tb_mpc_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpc_params.svh"
module tb_mpc_unit;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        issue = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [31:0] a_v = 32'h0;
  logic [31:0] b_v = 32'h0;
  logic        pfx_v = 1'b0;
  logic [15:0] pfx_h = 16'h0;
  logic        busy_ff, wr_en_ff, illegal_ff;
  logic [4:0]  wr_addr_ff;
  logic [31:0] wr_data_ff, last_wr;
  int          n_wr;
  logic        f_busy, f_wr_en, f_ill;
  logic [4:0]  f_addr;
  logic [31:0] f_data;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  initial forever #12.5 mclk = ~mclk;
  mpc_unit #(.AREA_OPT_SETTING(1), .HW_PRODUCT_LEVEL(2),
    .PATTERN_COMPARE_ENABLE(1)) i_dut (.mclk(mclk), .arst_n(arst_n),
    .issue(issue), .instr(instr), .first_source(a_v), .second_source(b_v),
    .imm_prefix_valid(pfx_v), .imm_prefix_high(pfx_h), .busy_ff(busy_ff),
    .wr_en_ff(wr_en_ff), .wr_addr_ff(wr_addr_ff), .wr_data_ff(wr_data_ff),
    .illegal_ff(illegal_ff));
  mpc_wb_model i_wb (.mclk(mclk), .arst_n(arst_n), .wr_en(wr_en_ff),
    .wr_addr(wr_addr_ff), .wr_data(wr_data_ff), .n_wr_ff(n_wr),
    .last_ff(last_wr));
  // second build: fast products, narrow multiplier, no compares
  mpc_unit #(.AREA_OPT_SETTING(0), .HW_PRODUCT_LEVEL(1),
    .PATTERN_COMPARE_ENABLE(0)) i_dut_fast (.mclk(mclk), .arst_n(arst_n),
    .issue(issue), .instr(instr), .first_source(a_v), .second_source(b_v),
    .imm_prefix_valid(pfx_v), .imm_prefix_high(pfx_h), .busy_ff(f_busy),
    .wr_en_ff(f_wr_en), .wr_addr_ff(f_addr), .wr_data_ff(f_data),
    .illegal_ff(f_ill));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] mk(logic [5:0] op, logic [4:0] rd,
    logic [15:0] lo);
    return {op, rd, 5'h01, lo};
  endfunction
  // refused issue held high during busy: an r7 write would show up
  task automatic ex(input logic [31:0] ins, a, b, input logic [16:0] pf,
    input int lat, input logic w, il, input logic [31:0] d);
    issue = 1'b1;
    instr = ins;
    a_v = a;
    b_v = b;
    {pfx_v, pfx_h} = pf;
    @(posedge mclk);
    #1;
    for (int i = 1; i < lat; i++)
    begin
      instr = mk(`MPC_OPC_OR, 5'h07, 16'h1000);
      chk("busy", 32'h1, {31'h0, busy_ff});
      chk("wr_en", 32'h0, {31'h0, wr_en_ff});
      @(posedge mclk);
      #1;
    end
    chk("busy", 32'h0, {31'h0, busy_ff});
    chk("wr_en", {31'h0, w}, {31'h0, wr_en_ff});
    chk("illegal", {31'h0, il}, {31'h0, illegal_ff});
    if (w)
    begin
      chk("addr", {27'h0, ins[25:21]}, {27'h0, wr_addr_ff});
      chk("data", d, wr_data_ff);
    end
  endtask
  task automatic idle;
    issue = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic t_prod;
    logic [31:0] a, b;
    logic [63:0] pu, ps, psu;
    a = 32'hfffffff0;
    b = 32'h80000003;
    pu = {32'h0, a} * {32'h0, b};
    ps = $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
    psu = $signed({{32{a[31]}}, a}) * $signed({32'h0, b});
    ex(mk(`MPC_OPC_MUL, 5'h03, 16'h1000), a, b, 17'h0, 3, 1, 0, pu[31:0]);
    ex(mk(`MPC_OPC_MUL, 5'h03, 16'h1001), a, b, 17'h0, 3, 1, 0, ps[63:32]);
    ex(mk(`MPC_OPC_MUL, 5'h03, 16'h1002), a, b, 17'h0, 3, 1, 0, psu[63:32]);
    ex(mk(`MPC_OPC_MUL, 5'h03, 16'h1003), a, b, 17'h0, 3, 1, 0, pu[63:32]);
    ex(mk(`MPC_OPC_MUL, 5'h03, 16'h1020), a, b, 17'h0, 1, 0, 1, 32'h0);
    ex(mk(`MPC_OPC_MUL, 5'h00, 16'h1000), a, b, 17'h0, 3, 0, 0, 32'h0);
    idle();
    $display("test products done");
  endtask
  task automatic t_imm;
    ex(mk(`MPC_OPC_MULI, 5'h09, 16'hfffd), 32'h12345, 0, 17'h0, 3, 1, 0, 32'h12345 * 32'hfffffffd);
    ex(mk(`MPC_OPC_MULI, 5'h09, 16'h0005), 32'h3, 0, 17'h10002, 3, 1, 0, 32'h3 * 32'h00020005);
    ex(mk(`MPC_OPC_ORI, 5'h0a, 16'h8001), 32'h0f00, 0, 17'h0, 1, 1, 0, 32'hffff8f01);
    ex(mk(`MPC_OPC_ORI, 5'h0a, 16'h8001), 32'h0f00, 0, 17'h10000, 1, 1, 0, 32'h00008f01);
    idle();
    $display("test immediates done");
  endtask
  task automatic t_logic;
    int n0;
    n0 = n_wr;
    ex(mk(`MPC_OPC_OR, 5'h04, 16'h1000), 32'h00f0_0f01, 32'h0f00_00f2, 17'h0, 1, 1, 0, 32'h0ff00ff3);
    ex(mk(`MPC_OPC_OR, 5'h05, 16'h1000), 32'h8000_0000, 32'h0000_0001, 17'h0, 1, 1, 0, 32'h80000001);
    ex({`MPC_OPC_OR, 26'h0}, 32'h0, 32'h0, 17'h0, 1, 0, 0, 32'h0);
    idle();
    chk("wb_last", 32'h80000001, last_wr);
    chk("wb_count", 32'(n0 + 2), 32'(n_wr));
    chk("wb_r5", 32'h80000001, i_wb.regs_ff[5]);
    $display("test logic done");
  endtask
  task automatic t_pcmp;
    logic [31:0] bv [5];
    int          pos [5];
    bv = '{32'h11223344, 32'h00223300, 32'h00003344, 32'h00000044, 32'h55667788};
    pos = '{1, 2, 3, 4, 0};
    for (int i = 0; i < 5; i++)
      ex(mk(`MPC_OPC_OR, 5'h06, 16'h1400), 32'h11223344, bv[i], 17'h0, 1, 1, 0, pos[i]);
    for (int i = 0; i < 2; i++)
    begin
      ex(mk(`MPC_OPC_PCMPEQ, 5'h06, 16'h1400), 32'h5a5a0001, 32'h5a5a0001 ^ i, 17'h0, 1, 1, 0, 32'(i == 0));
      ex(mk(`MPC_OPC_PCMPNE, 5'h06, 16'h1400), 32'h5a5a0001, 32'h5a5a0001 ^ i, 17'h0, 1, 1, 0, 32'(i != 0));
    end
    ex(mk(6'h3f, 5'h06, 16'h1400), 32'h1, 32'h1, 17'h0, 1, 0, 1, 32'h0);
    idle();
    $display("test compares done");
  endtask
  // main build refuses the later words while busy with the first product
  task automatic t_fast;
    issue = 1'b1;
    instr = mk(`MPC_OPC_MUL, 5'h03, 16'h1000);
    a_v = 32'hfffffff0;
    b_v = 32'h00000010;
    {pfx_v, pfx_h} = 17'h0;
    @(posedge mclk);
    #1;
    chk("f_data", 32'hffffff00, f_data);
    chk("f_wr_en", 32'h1, {31'h0, f_wr_en});
    chk("f_addr", 32'h3, {27'h0, f_addr});
    chk("f_busy", 32'h0, {31'h0, f_busy});
    instr = mk(`MPC_OPC_MUL, 5'h03, 16'h1001);
    @(posedge mclk);
    #1;
    chk("f_illegal", 32'h1, {31'h0, f_ill});
    chk("f_wr_en", 32'h0, {31'h0, f_wr_en});
    instr = mk(`MPC_OPC_PCMPEQ, 5'h03, 16'h1400);
    @(posedge mclk);
    #1;
    chk("f_illegal", 32'h1, {31'h0, f_ill});
    idle();
    $display("test fast build done");
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    t_prod();
    t_imm();
    t_logic();
    t_pcmp();
    t_fast();
    end_sim();
  end
endmodule // tb_mpc_unit
`default_nettype wire
